// ---- reset_sequencer_pkg.sv ----
// shared constants and types for the reset sequencer
package reset_sequencer_pkg;

    localparam int unsigned CLK_HZ          = 20_000_000;
    localparam int unsigned OSC_START_NS    = 4000;
    localparam int unsigned OSC_START_CYC   = (OSC_START_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int unsigned HOLD_SHORT_CYC  = 66;
    localparam int unsigned HOLD_LONG_CYC   = 5000;
    localparam int unsigned CNT_W           = 13;
    localparam int unsigned GPIO_W          = 8;
    // length in cycles of the settle window after the pin is let go
    localparam int unsigned PIN_SETTLE_CYC  = 4;

    localparam logic [15:0] VECTOR_HI_ADDR  = 16'h0002;
    localparam logic [15:0] VECTOR_LO_ADDR  = 16'h0003;

    localparam int unsigned PWR_AMP_BIT     = 7;
    localparam logic [7:0]  PWR_CTRL_RESET  = 8'h80;
    localparam logic [1:0]  CLK_SRC_INT_OSC = 2'h0;

    typedef enum logic [4:0] {
        ST_OSC_START = 5'b0_0001,
        ST_HOLD      = 5'b0_0010,
        ST_PIN_WAIT  = 5'b0_0100,
        ST_VEC_FETCH = 5'b0_1000,
        ST_RUN       = 5'b1_0000
    } seq_state_t;

    typedef struct packed {
        logic power_on;
        logic brownout_detect;
        logic watchdog_timeout;
        logic stop_exit;
        logic pin_reset_n;
    } reset_causes_t;

    typedef struct packed {
        logic       vec_req;
        logic       vec_byte;
        logic [7:0] vec_hi;
        logic       pc_load;
        logic [15:0] pc_value;
    } vector_t;

endpackage : reset_sequencer_pkg

// ---- reset_sequencer.sv ----
// reset request merge, hold counter, vector fetch and power-on-only register
// What this block does
// - any of five causes enters reset
// - wait oscillator start-up before counting
// - hold core reset 66 oscillator cycles
// - crystal option lengthens hold to 5000
// - supply faults count from supply good
// - stay in reset while pin asserted
// - gpio become inputs, pull-ups off
// - reset pin open-drain, driven low
// - core idle, crystal and watchdog run
// - control registers take reset values
// - fetch vector from 0002H/0003H into pc
// - clock source returns to internal oscillator
// - amplifier off by default, clear enables
// - power register set to 80H only at power-on
// - amplifier disable bit 7, resets one
module reset_sequencer
    import reset_sequencer_pkg::*;
(
    input  wire logic          clk,
    input  wire logic          resetn,
    input  wire logic          power_on,
    input  wire logic          brownout_detect,
    input  wire logic          watchdog_timeout,
    input  wire logic          stop_exit,
    input  wire logic          supply_good,
    input  wire logic          crystal_option,
    input  wire logic          reset_shared_pin_i,
    output logic               reset_shared_pin_o,
    output logic               reset_shared_pin_oe,
    output logic               core_reset,
    output logic               periph_reset,
    output logic               ctrl_reg_load,
    output logic [GPIO_W-1:0]  gpio_force_input,
    output logic [GPIO_W-1:0]  gpio_pullup_off,
    output logic               crystal_run,
    output logic               watchdog_osc_run,
    output logic [1:0]         clock_source_sel,
    output logic [15:0]        vec_addr,
    output logic               vec_req,
    input  wire logic [7:0]    vec_data,
    input  wire logic          vec_valid,
    output logic               pc_load,
    output logic [15:0]        pc_value,
    input  wire logic          pwr_wr,
    input  wire logic [7:0]    pwr_wdata,
    output logic [7:0]         pwr_ctrl,
    output logic               low_power_amp_en
);

    typedef struct packed {
        logic [2:0]  pin_sync;
        logic        pin_n;
        reset_causes_t causes_prev;
        seq_state_t  state;
        logic [CNT_W-1:0] cnt;
        logic        supply_wait;
        logic        pin_drive;
        logic        vec_byte;
        logic [7:0]  vec_hi;
        logic        pc_load;
        logic [15:0] pc_value;
        logic [7:0]  pwr_ctrl;
    } state_t;

    state_t s_q;
    state_t s_d;
    reset_causes_t cur;
    logic new_cause;
    logic pin_asserted;
    logic [CNT_W-1:0] hold_len;

    always_comb
    begin
        s_d = s_q;
        s_d.pc_load = 1'b0;
        // pin passes three flops; a change counts when the last two agree
        s_d.pin_sync = {s_q.pin_sync[1:0], reset_shared_pin_i};
        if (s_q.pin_sync[2] == s_q.pin_sync[1])
        begin
            s_d.pin_n = s_q.pin_sync[2];
        end
        pin_asserted = !s_q.pin_n;
        cur.power_on = power_on;
        cur.brownout_detect = brownout_detect;
        cur.watchdog_timeout = watchdog_timeout;
        cur.stop_exit = stop_exit;
        // own drive low is not a new external cause; the synced pin lags the
        // release by a few cycles, so the settle window is masked as well,
        // otherwise the lagging low would restart the sequence forever
        cur.pin_reset_n = s_q.pin_n | s_q.pin_drive | (s_q.state == ST_PIN_WAIT);
        s_d.causes_prev = cur;

        // causes count on their edges; a level held high never retriggers
        new_cause = 1'b0;
        if (cur.power_on && !s_q.causes_prev.power_on)
        begin
            new_cause = 1'b1;
        end
        if (cur.brownout_detect && !s_q.causes_prev.brownout_detect)
        begin
            new_cause = 1'b1;
        end
        if (cur.watchdog_timeout && !s_q.causes_prev.watchdog_timeout)
        begin
            new_cause = 1'b1;
        end
        if (cur.stop_exit && !s_q.causes_prev.stop_exit)
        begin
            new_cause = 1'b1;
        end
        if (!cur.pin_reset_n && s_q.causes_prev.pin_reset_n)
        begin
            new_cause = 1'b1;
        end

        if (crystal_option)
        begin
            hold_len = CNT_W'(HOLD_LONG_CYC);
        end
        else
        begin
            hold_len = CNT_W'(HOLD_SHORT_CYC);
        end

        if (power_on)
        begin
            s_d.pwr_ctrl = PWR_CTRL_RESET;
        end
        else if (pwr_wr && s_q.state == ST_RUN)
        begin
            s_d.pwr_ctrl = pwr_wdata;
        end
        if (new_cause)
        begin
            // restart from scratch; pin is pulled low again during port reset
            s_d.state = ST_OSC_START;
            s_d.cnt = '0;
            s_d.supply_wait = power_on | brownout_detect | s_q.supply_wait;
            s_d.pin_drive = 1'b1;
        end
        else
        begin
            case (s_q.state)
                ST_OSC_START:
                begin
                    if (s_q.supply_wait && !supply_good)
                    begin
                        s_d.cnt = '0;
                    end
                    else if (s_q.cnt >= CNT_W'(OSC_START_CYC - 1))
                    begin
                        s_d.supply_wait = 1'b0;
                        s_d.cnt = '0;
                        s_d.state = ST_HOLD;
                    end
                    else
                    begin
                        s_d.cnt = s_q.cnt + 1'b1;
                    end
                end
                ST_HOLD:
                begin
                    if (s_q.cnt >= hold_len - 1'b1)
                    begin
                        s_d.cnt = '0;
                        s_d.pin_drive = 1'b0;
                        s_d.state = ST_PIN_WAIT;
                    end
                    else
                    begin
                        s_d.cnt = s_q.cnt + 1'b1;
                    end
                end
                ST_PIN_WAIT:
                begin
                    // sync delay lets the released pin settle before it is judged
                    if (s_q.cnt < CNT_W'(PIN_SETTLE_CYC))
                    begin
                        s_d.cnt = s_q.cnt + 1'b1;
                    end
                    else if (!pin_asserted)
                    begin
                        s_d.vec_byte = 1'b0;
                        s_d.state = ST_VEC_FETCH;
                    end
                end
                ST_VEC_FETCH:
                begin
                    if (vec_valid)
                    begin
                        if (!s_q.vec_byte)
                        begin
                            s_d.vec_hi = vec_data;
                            s_d.vec_byte = 1'b1;
                        end
                        else
                        begin
                            s_d.pc_value = {s_q.vec_hi, vec_data};
                            s_d.pc_load = 1'b1;
                            s_d.state = ST_RUN;
                        end
                    end
                end
                ST_RUN:
                begin
                    s_d.cnt = '0;
                end
                default:
                begin
                    s_d.state = ST_OSC_START;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            s_q.pin_sync <= 3'h7;
            s_q.pin_n <= 1'b1;
            s_q.causes_prev <= 5'h01;
            s_q.state <= ST_OSC_START;
            s_q.cnt <= '0;
            s_q.supply_wait <= 1'b1;
            s_q.pin_drive <= 1'b1;
            s_q.vec_byte <= 1'b0;
            s_q.vec_hi <= 8'h00;
            s_q.pc_load <= 1'b0;
            s_q.pc_value <= 16'h0000;
            s_q.pwr_ctrl <= PWR_CTRL_RESET;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    logic in_reset;
    assign in_reset = (s_q.state != ST_RUN);
    assign core_reset = in_reset && (s_q.state != ST_VEC_FETCH);
    assign periph_reset = in_reset;
    assign ctrl_reg_load = in_reset;

    // one mask bit per port pin; the reset-shared pin is driven on its own
    for (genvar g = 0; g < GPIO_W; g++)
    begin : gen_gpio
        assign gpio_force_input[g] = in_reset;
        assign gpio_pullup_off[g]  = in_reset;
    end

    assign crystal_run = 1'b1;
    assign watchdog_osc_run = 1'b1;
    // other sources are software's job once running
    assign clock_source_sel = CLK_SRC_INT_OSC;
    assign reset_shared_pin_o = 1'b0;
    assign reset_shared_pin_oe = s_q.pin_drive;
    assign vec_req = (s_q.state == ST_VEC_FETCH);
    assign vec_addr = s_q.vec_byte ? VECTOR_LO_ADDR : VECTOR_HI_ADDR;
    assign pc_load = s_q.pc_load;
    assign pc_value = s_q.pc_value;
    assign pwr_ctrl = s_q.pwr_ctrl;
    assign low_power_amp_en = !s_q.pwr_ctrl[PWR_AMP_BIT];

endmodule // reset_sequencer

// ---- reset_sequencer_sva.sv ----
// assertions on the reset sequencer ports
module reset_sequencer_sva
    import reset_sequencer_pkg::*;
(
    input wire logic        clk,
    input wire logic        resetn,
    input wire logic        power_on,
    input wire logic        watchdog_timeout,
    input wire logic        crystal_option,
    input wire logic        reset_shared_pin_i,
    input wire logic        reset_shared_pin_oe,
    input wire logic        core_reset,
    input wire logic        periph_reset,
    input wire logic        ctrl_reg_load,
    input wire logic [7:0]  gpio_force_input,
    input wire logic [7:0]  gpio_pullup_off,
    input wire logic        crystal_run,
    input wire logic        watchdog_osc_run,
    input wire logic [1:0]  clock_source_sel,
    input wire logic        vec_req,
    input wire logic [15:0] vec_addr,
    input wire logic        pwr_wr,
    input wire logic [7:0]  pwr_wdata,
    input wire logic [7:0]  pwr_ctrl,
    input wire logic        low_power_amp_en
);
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    // length of the current pin pull-down
    logic [15:0] oe_n_q;
    always_ff @(posedge clk or negedge resetn)
        if (!resetn)
            oe_n_q <= 16'h0000;
        else
            oe_n_q <= reset_shared_pin_oe ? oe_n_q + 16'h0001 : 16'h0000;
    chk_cause_enters: assert property ($rose(watchdog_timeout) |-> ##[1:3] core_reset && reset_shared_pin_oe)
        else $error("cause ignored");
    chk_short_hold: assert property ($fell(reset_shared_pin_oe) && !crystal_option |-> oe_n_q >= 16'h0091)
        else $error("short hold too brief");
    chk_long_hold: assert property ($fell(reset_shared_pin_oe) && crystal_option |-> oe_n_q >= 16'h13d7)
        else $error("long hold too brief");
    chk_pin_release: assert property ($rose(vec_req) |-> $past(reset_shared_pin_i, 3))
        else $error("left reset with pin low");
    chk_gpio_input: assert property (reset_shared_pin_oe |-> &gpio_force_input && &gpio_pullup_off)
        else $error("gpio not forced");
    chk_core_idle: assert property (reset_shared_pin_oe |-> periph_reset && ctrl_reg_load && crystal_run && watchdog_osc_run)
        else $error("idle state wrong");
    chk_vec_first: assert property ($rose(vec_req) |-> vec_addr == VECTOR_HI_ADDR)
        else $error("vector order wrong");
    chk_clock_source: assert property ($fell(core_reset) |-> clock_source_sel == CLK_SRC_INT_OSC)
        else $error("clock source wrong");
    chk_pwr_write: assert property (pwr_wr && !periph_reset |=> pwr_ctrl == $past(pwr_wdata) && low_power_amp_en != pwr_ctrl[7])
        else $error("power write lost");
    chk_pwr_keep: assert property ($changed(pwr_ctrl) |-> power_on || $past(power_on) || $past(pwr_wr) && !$past(periph_reset))
        else $error("power register disturbed");
    cover property ($fell(core_reset));
    cover property ($fell(reset_shared_pin_oe) && crystal_option);
    cover property (vec_req && !reset_shared_pin_oe);
endmodule // reset_sequencer_sva

bind reset_sequencer reset_sequencer_sva reset_sequencer_sva_i (.*);

// ---- reset_partner.sv ----
// program memory and pulled-up reset pin
module reset_partner
    import reset_sequencer_pkg::*;
(
    input wire logic        clk,
    input wire logic        vec_req,
    input wire logic [15:0] vec_addr,
    output logic [7:0]      vec_data,
    output logic            vec_valid,
    input wire logic        ext_pin_n,
    input wire logic        pin_o,
    input wire logic        pin_oe,
    output logic            pin_level,
    input wire logic [1:0]  slow
);
    logic [1:0] wait_q = 2'h0;
    assign pin_level = ext_pin_n & ~(pin_oe & ~pin_o);
    initial vec_valid = 1'b0;
    initial vec_data = 8'h00;
    always @(posedge clk)
    begin
        vec_valid <= 1'b0;
        // idle bus toggles so a stale byte never matches
        vec_data <= ~vec_data;
        wait_q <= 2'h0;
        if (vec_req && !vec_valid)
        begin
            wait_q <= wait_q + 2'h1;
            if (wait_q == slow)
            begin
                vec_valid <= 1'b1;
                vec_data <= (vec_addr == VECTOR_HI_ADDR) ? 8'h5a : (vec_addr == VECTOR_LO_ADDR) ? 8'hc3 : 8'hff;
            end
        end
    end
endmodule // reset_partner

// ---- reset_sequencer_bench.sv ----
// self-checking bench for the reset sequencer
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin n_fail++; $display("ERROR t=%0t got=%h exp=%h", $time, (a), (b)); end end
module reset_sequencer_bench
    import reset_sequencer_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk, resetn, power_on, brownout_detect, watchdog_timeout, stop_exit;
    logic        supply_good, crystal_option, ext_pin_n, pwr_wr, pin_i, pin_o, pin_oe;
    logic        core_reset, periph_reset, ctrl_reg_load, vec_req, vec_valid, pc_load, low_power_amp_en;
    logic [7:0]  pwr_wdata, vec_data, pwr_ctrl;
    logic [15:0] vec_addr, pc_value;
    logic [1:0]  slow, clock_source_sel;
    int          n_fail = 0;
    int          total_checks = 0;
    int          cyc = 0;
    reset_sequencer reset_sequencer_i (.*, .reset_shared_pin_i(pin_i), .reset_shared_pin_o(pin_o),
        .reset_shared_pin_oe(pin_oe), .gpio_force_input(), .gpio_pullup_off(), .crystal_run(), .watchdog_osc_run());
    reset_partner reset_partner_i (.clk, .vec_req, .vec_addr, .vec_data, .vec_valid, .ext_pin_n, .pin_o, .pin_oe,
        .pin_level(pin_i), .slow);
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    task automatic conclude();
        $display("checks=%0d failures=%0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // a hang counts as a failure
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            n_fail++;
            conclude();
        end
    end
    task automatic fire(input int k);
        @(posedge clk);
        watchdog_timeout <= (k == 0);
        stop_exit <= (k == 1);
        brownout_detect <= (k == 2);
        power_on <= (k == 3);
        @(posedge clk);
        {watchdog_timeout, stop_exit, brownout_detect, power_on} <= 4'h0;
    endtask
    // pull-down length, then the vector lands in pc
    task automatic boot(input int lo, input int hi);
        int n;
        n = 0;
        #1;
        while (pin_oe !== 1'b1 && n < 10) begin @(posedge clk); #1; n++; end
        n = 0;
        while (pin_oe === 1'b1 && n < 9000) begin @(posedge clk); #1; n++; end
        `CHK(n >= lo && n <= hi, 1'b1)
        n = 0;
        while (pc_load !== 1'b1 && n < 100) begin @(posedge clk); #1; n++; end
        `CHK(pc_value, 16'h5ac3)
        `CHK({core_reset, clock_source_sel}, 3'h0)
        repeat (2) @(posedge clk);
    endtask
    task automatic sc_amp();
        pwr_wr <= 1'b1;
        pwr_wdata <= 8'h00;
        @(posedge clk);
        pwr_wr <= 1'b0;
        #1;
        `CHK({pwr_ctrl, low_power_amp_en}, 9'h001)
        slow <= 2'h3;
        for (int k = 0; k < 3; k++)
        begin
            fire(k);
            boot(144, 148);
            `CHK(pwr_ctrl, 8'h00)
        end
    endtask
    task automatic sc_restart();
        fire(1);
        repeat (100) @(posedge clk);
        supply_good <= 1'b0;
        fire(2);
        pwr_wr <= 1'b1;
        pwr_wdata <= 8'hff;
        repeat (30) @(posedge clk);
        `CHK(pin_oe, 1'b1)
        pwr_wr <= 1'b0;
        supply_good <= 1'b1;
        boot(144, 148);
        `CHK(pwr_ctrl, 8'h00)
    endtask
    task automatic sc_pin();
        @(posedge clk);
        ext_pin_n <= 1'b0;
        repeat (100) @(posedge clk);
        #1;
        `CHK({pin_oe, pin_o}, 2'h2)
        repeat (300) @(posedge clk);
        #1;
        `CHK({core_reset, pin_oe, vec_req}, 3'h4)
        @(posedge clk);
        ext_pin_n <= 1'b1;
        boot(0, 0);
    endtask
    initial
    begin
        {power_on, brownout_detect, watchdog_timeout, stop_exit, crystal_option, pwr_wr} = 6'h00;
        {resetn, supply_good, ext_pin_n, pwr_wdata, slow} = 13'h0c00;
        repeat (20) @(posedge clk);
        resetn <= 1'b1;
        boot(144, 148);
        sc_amp();
        sc_restart();
        sc_pin();
        crystal_option <= 1'b1;
        fire(0);
        boot(5078, 5082);
        crystal_option <= 1'b0;
        fire(3);
        boot(144, 148);
        `CHK({pwr_ctrl, low_power_amp_en}, 9'h100)
        conclude();
    end
endmodule // reset_sequencer_bench
